// >>> atx_pkg.sv
// Constants, register map and state encoding for the ATX host power control block
`default_nettype none
package atx_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICKS_PER_S = 32;
  localparam int TICK_CYCLES_DEF = CLK_HZ / TICKS_PER_S;
  // Key-hold and pulse times in milliseconds
  localparam int ON_HOLD_MS = 250;
  localparam int OFF_HOLD_MS = 4000;
  localparam int RST_HOLD_MS = 4000;
  localparam int RST_PULSE_MS = 1000;
  localparam int OFF_EXT_MS = 5000;
  // Least times round up, the longest time rounds down
  localparam logic [7:0] ON_HOLD_TICKS = 8'((ON_HOLD_MS * TICKS_PER_S + 999) / 1000);
  localparam logic [7:0] OFF_HOLD_TICKS = 8'((OFF_HOLD_MS * TICKS_PER_S + 999) / 1000);
  localparam logic [7:0] RST_HOLD_TICKS = 8'((RST_HOLD_MS * TICKS_PER_S + 999) / 1000);
  localparam logic [7:0] RST_PULSE_TICKS = 8'((RST_PULSE_MS * TICKS_PER_S + 999) / 1000);
  localparam logic [7:0] OFF_EXT_TICKS = 8'((OFF_EXT_MS * TICKS_PER_S) / 1000);
  // Register byte addresses
  localparam logic [4:0] ADDR_FUNC = 5'h00;
  localparam logic [4:0] ADDR_PULSE = 5'h04;
  localparam logic [4:0] ADDR_SENSE = 5'h08;
  localparam logic [4:0] ADDR_STORE = 5'h0C;
  localparam logic [4:0] ADDR_WDOG = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  // Function byte fields and the watchdog fire bit
  localparam int FUNC_AUTO_POL = 0;
  localparam int FUNC_PWR_INV = 1;
  localparam int FUNC_RST_INV = 2;
  localparam int FUNC_KRESET = 4;
  localparam int FUNC_KON = 5;
  localparam int FUNC_KOFF = 6;
  localparam int FUNC_BLANK = 7;
  localparam int WDOG_FIRE = 0;
  // Reset values and the connector sense select value
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [7:0] PULSE_RST = 8'h20;
  localparam logic [7:0] SENSE_RST = 8'h01;
  localparam logic [7:0] SENSE_CONNECTOR = 8'h01;
  // Synchronised input positions
  localparam int IN_ACCEPT = 0;
  localparam int IN_CANCEL = 1;
  localparam int IN_SENSE_CONN = 2;
  localparam int IN_SENSE_GPIO = 3;
  localparam int IN_PWR_LINE = 4;
  localparam int IN_RST_LINE = 5;
  localparam int IN_W = 6;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ON = 3'b001,
    S_OFF_MIN = 3'b010,
    S_OFF_EXT = 3'b011,
    S_KRST = 3'b100,
    S_WRST = 3'b101
  } state_type;
endpackage
`default_nettype wire

// >>> in_sync3.sv
// Three-stage pin synchroniser; output moves once stages two and three agree
`default_nettype none
module in_sync3 #(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: a value that held for two samples is taken
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= '0;
    end else begin
      o_q <= (s2_q & s3_q) | (o_q & (s2_q | s3_q));
    end
  end
endmodule
`default_nettype wire

// >>> atx_host_power_control.sv
// Keypad driven ATX power and reset switch control with Avalon-MM registers
//
// Chosen here: the address map and the Avalon-MM register port.
`default_nettype none
module atx_host_power_control
  import atx_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_accept_key,
  input wire logic i_cancel_key,
  input wire logic i_sense_connector_pin,
  input wire logic i_sense_gpio_pin,
  input wire logic i_pwr_sw_in,
  output logic o_pwr_sw_out,
  output logic o_pwr_sw_oe,
  input wire logic i_rst_sw_in,
  output logic o_rst_sw_out,
  output logic o_rst_sw_oe,
  output logic o_blank,
  output logic o_restart
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic rst_meta_q;
  logic rst_n;
  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] syn;
  logic [TW-1:0] div_q;
  logic tick_q;
  logic [7:0] func_q;
  logic [7:0] pulse_q;
  logic [7:0] sense_sel_q;
  logic [7:0] boot_func_q;
  logic [7:0] boot_pulse_q;
  logic [7:0] boot_sense_q;
  logic wd_pend_q;
  logic restart_q;
  logic [7:0] acc_cnt_q;
  logic [7:0] can_cnt_q;
  logic [7:0] pcnt_q;
  state_type state_q;
  logic pwr_idle_q;
  logic rst_idle_q;
  logic pwr_lvl_q;
  logic rst_lvl_q;
  logic sense;
  logic accept;
  logic cancel;
  logic on_hit;
  logic off_hit;
  logic krst_hit;
  logic pulse_done;
  logic wr_take;
  logic rd_take;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  assign pins = {i_rst_sw_in, i_pwr_sw_in, i_sense_gpio_pin, i_sense_connector_pin,
                 i_cancel_key, i_accept_key};

  in_sync3 #(.W(IN_W)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_d(pins),
    .o_q(syn)
  );

  assign accept = syn[IN_ACCEPT];
  assign cancel = syn[IN_CANCEL];
  // Source select for host power sense
  assign sense = (sense_sel_q == SENSE_CONNECTOR) ? syn[IN_SENSE_CONN] : syn[IN_SENSE_GPIO];

  ////////////////////////////////////////////////////////////////////////////
  // Tick timebase, free running so holds and pulses share one grid
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == TICK_LAST);
      div_q <= (div_q == TICK_LAST) ? '0 : div_q + TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the transfer completes
  assign rd_take = i_avs_read && o_avs_waitrequest;
  assign wr_take = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      case (i_avs_address)
        ADDR_FUNC: o_avs_readdata <= {24'h00_0000, func_q};
        ADDR_PULSE: o_avs_readdata <= {24'h00_0000, pulse_q};
        ADDR_SENSE: o_avs_readdata <= {24'h00_0000, sense_sel_q};
        ADDR_WDOG: o_avs_readdata <= {31'h0000_0000, wd_pend_q};
        ADDR_STATUS: o_avs_readdata <= {24'h00_0000, sense, o_blank, o_rst_sw_oe,
                                        o_pwr_sw_oe, wd_pend_q, state_q};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Live settings; a self restart reloads the stored power-up copy
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= FUNC_RST;
      pulse_q <= PULSE_RST;
      sense_sel_q <= SENSE_RST;
    end else if (restart_q) begin
      func_q <= boot_func_q;
      pulse_q <= boot_pulse_q;
      sense_sel_q <= boot_sense_q;
    end else if (wr_take) begin
      if (i_avs_address == ADDR_FUNC) func_q <= i_avs_writedata[7:0];
      if (i_avs_address == ADDR_PULSE) pulse_q <= i_avs_writedata[7:0];
      if (i_avs_address == ADDR_SENSE) sense_sel_q <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_func_q <= FUNC_RST;
      boot_pulse_q <= PULSE_RST;
      boot_sense_q <= SENSE_RST;
    end else if (wr_take && i_avs_address == ADDR_STORE) begin
      boot_func_q <= func_q;
      boot_pulse_q <= pulse_q;
      boot_sense_q <= sense_sel_q;
    end
  end

  // Pending watchdog request; a new request beats the acceptance clear
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_pend_q <= 1'b0;
    end else if (wr_take && i_avs_address == ADDR_WDOG && i_avs_writedata[WDOG_FIRE]) begin
      wd_pend_q <= 1'b1;
    end else if (state_q == S_IDLE) begin
      wd_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key hold timers in ticks, cleared on release
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt_q <= 8'h00;
      can_cnt_q <= 8'h00;
    end else begin
      if (!accept) acc_cnt_q <= 8'h00;
      else if (tick_q && acc_cnt_q != 8'hFF) acc_cnt_q <= acc_cnt_q + 8'h01;
      if (!cancel) can_cnt_q <= 8'h00;
      else if (tick_q && can_cnt_q != 8'hFF) can_cnt_q <= can_cnt_q + 8'h01;
    end
  end

  // A hold fires once, on the tick that completes it
  assign on_hit = func_q[FUNC_KON] && !sense && accept && tick_q &&
                  acc_cnt_q == ON_HOLD_TICKS - 8'h01;
  assign krst_hit = func_q[FUNC_KRESET] && sense && accept && tick_q &&
                    acc_cnt_q == RST_HOLD_TICKS - 8'h01;
  assign off_hit = func_q[FUNC_KOFF] && sense && cancel && tick_q &&
                   can_cnt_q == OFF_HOLD_TICKS - 8'h01;
  // Width 0 behaves as one tick
  assign pulse_done = tick_q && (9'(pcnt_q) + 9'h001 >= 9'(pulse_q));

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      pcnt_q <= 8'h00;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (tick_q) pcnt_q <= pcnt_q + 8'h01;
      case (state_q)
        S_IDLE: begin
          pcnt_q <= 8'h00;
          // Watchdog first: a hung host outranks a key
          if (wd_pend_q) state_q <= S_WRST;
          else if (off_hit) state_q <= S_OFF_MIN;
          else if (on_hit) state_q <= S_ON;
          else if (krst_hit) state_q <= S_KRST;
        end
        S_ON: if (pulse_done) state_q <= S_IDLE;
        S_OFF_MIN: begin
          if (pulse_done) begin
            state_q <= cancel ? S_OFF_EXT : S_IDLE;
            pcnt_q <= 8'h00;
          end
        end
        S_OFF_EXT: if (!cancel || (tick_q && pcnt_q == OFF_EXT_TICKS - 8'h01))
          state_q <= S_IDLE;
        S_KRST: begin
          if (tick_q && pcnt_q == RST_PULSE_TICKS - 8'h01) begin
            state_q <= S_IDLE;
            restart_q <= 1'b1;
          end
        end
        S_WRST: if (tick_q && pcnt_q == RST_PULSE_TICKS - 8'h01)
          state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers; auto polarity drives against the released level
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_idle_q <= 1'b1;
      rst_idle_q <= 1'b1;
      pwr_lvl_q <= 1'b0;
      rst_lvl_q <= 1'b0;
    end else begin
      if (!o_pwr_sw_oe) pwr_idle_q <= syn[IN_PWR_LINE];
      if (!o_rst_sw_oe) rst_idle_q <= syn[IN_RST_LINE];
      if (state_q == S_IDLE) begin
        pwr_lvl_q <= func_q[FUNC_AUTO_POL] ? !pwr_idle_q : func_q[FUNC_PWR_INV];
        rst_lvl_q <= func_q[FUNC_AUTO_POL] ? !rst_idle_q : func_q[FUNC_RST_INV];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pwr_sw_oe <= 1'b0;
      o_pwr_sw_out <= 1'b0;
      o_rst_sw_oe <= 1'b0;
      o_rst_sw_out <= 1'b0;
      o_blank <= 1'b0;
      o_restart <= 1'b0;
    end else begin
      o_pwr_sw_oe <= state_q inside {S_ON, S_OFF_MIN, S_OFF_EXT};
      o_pwr_sw_out <= (state_q inside {S_ON, S_OFF_MIN, S_OFF_EXT}) && pwr_lvl_q;
      o_rst_sw_oe <= state_q inside {S_KRST, S_WRST};
      o_rst_sw_out <= (state_q inside {S_KRST, S_WRST}) && rst_lvl_q;
      o_blank <= func_q[FUNC_BLANK] && !sense;
      o_restart <= restart_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  a_pwr_released: assert property (!(state_q inside {S_ON, S_OFF_MIN, S_OFF_EXT})
    |=> !o_pwr_sw_oe) else $error("power line driven outside a command");
  a_pwr_level: assert property ((state_q == S_IDLE && !func_q[FUNC_AUTO_POL]
    ##1 state_q == S_ON) |=> o_pwr_sw_out == $past(func_q[FUNC_PWR_INV], 2))
    else $error("power drive level wrong");
  a_rst_released: assert property (!(state_q inside {S_KRST, S_WRST})
    |=> !o_rst_sw_oe) else $error("reset line driven outside a reset");
  a_wdog_reset: assert property ((state_q == S_IDLE && wd_pend_q)
    |=> state_q == S_WRST ##1 o_rst_sw_oe) else $error("watchdog did not drive reset");
  a_on_gated: assert property ((state_q == S_IDLE && !func_q[FUNC_KON])
    |=> state_q != S_ON) else $error("power on without enable");
  a_on_start: assert property ((state_q == S_IDLE && !wd_pend_q && !off_hit && on_hit)
    |=> state_q == S_ON) else $error("accept hold did not start power on");
  a_off_minimum: assert property ((state_q == S_OFF_MIN ##1 state_q != S_OFF_MIN)
    |-> 9'($past(pcnt_q)) + 9'h001 >= 9'($past(pulse_q)))
    else $error("hard off shorter than width");
  a_off_ext_bound: assert property (state_q == S_OFF_EXT |-> pcnt_q < OFF_EXT_TICKS)
    else $error("hard off extension too long");
  a_rst_width: assert property ((state_q == S_KRST ##1 state_q == S_IDLE)
    |-> $past(pcnt_q) == RST_PULSE_TICKS - 8'h01 && $past(tick_q))
    else $error("keypad reset not one second");
  a_restart_after: assert property ((state_q == S_KRST ##1 state_q == S_IDLE)
    |=> o_restart ##1 func_q == boot_func_q) else $error("no restart after reset");
  a_blank_follow: assert property ((func_q[FUNC_BLANK] && !sense) |=> o_blank)
    else $error("display not blanked with host off");
  a_func_write: assert property ((wr_take && !restart_q && i_avs_address == ADDR_FUNC
    && i_avs_writedata[7:0] == 8'hF1) |=> func_q[FUNC_KOFF] && func_q[FUNC_KON]
    && func_q[FUNC_KRESET] && func_q[FUNC_BLANK] && func_q[FUNC_AUTO_POL])
    else $error("function byte 241 not applied");
  a_store_copy: assert property ((wr_take && i_avs_address == ADDR_STORE
    && !restart_q) |=> boot_pulse_q == $past(pulse_q)) else $error("store did not save");
  a_tick_single: assert property (tick_q |=> !tick_q) else $error("tick wider than 1");

  c_power_on: cover property (state_q == S_ON ##1 state_q == S_IDLE);
  c_off_extend: cover property (state_q == S_OFF_MIN ##1 state_q == S_OFF_EXT);
  c_key_reset: cover property (o_restart);
  c_watchdog: cover property (state_q == S_WRST);
endmodule
`default_nettype wire

// >>> atx_board_model.sv
// Motherboard model of the power and reset switch inputs
`default_nettype none
module atx_board_model (
  input wire logic i_pwr_oe,
  input wire logic i_pwr_out,
  input wire logic i_rst_oe,
  input wire logic i_rst_out,
  output logic o_pwr_line,
  output logic o_rst_line
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // Board inputs only listen; pull-ups set the level whenever released
  assign o_pwr_line = i_pwr_oe ? i_pwr_out : 1'b1;
  assign o_rst_line = i_rst_oe ? i_rst_out : 1'b1;
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the ATX host power control block
`default_nettype none
module tb import atx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps multi-second holds to a few hundred cycles
  localparam int T = 4;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic accept = 1'b0;
  logic cancel = 1'b0;
  logic sense_conn = 1'b0;
  logic sense_gpio = 1'b1;
  logic pwr_line, rst_line, waitreq, pwr_out, pwr_oe, rst_out, rst_oe, blank, restart;
  logic [31:0] readdata;
  int errors = 0;
  int checks = 0;
  int w, l;
  logic v;
  always #10 ref_clk = ~ref_clk;
  atx_host_power_control #(.TICK_CYCLES(T)) DUT (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_avs_address(address), .i_avs_read(read),
    .i_avs_write(write), .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .i_accept_key(accept),
    .i_cancel_key(cancel), .i_sense_connector_pin(sense_conn), .i_sense_gpio_pin(sense_gpio),
    .i_pwr_sw_in(pwr_line), .o_pwr_sw_out(pwr_out), .o_pwr_sw_oe(pwr_oe),
    .i_rst_sw_in(rst_line), .o_rst_sw_out(rst_out), .o_rst_sw_oe(rst_oe),
    .o_blank(blank), .o_restart(restart));
  atx_board_model board (.i_pwr_oe(pwr_oe), .i_pwr_out(pwr_out), .i_rst_oe(rst_oe),
    .i_rst_out(rst_out), .o_pwr_line(pwr_line), .o_rst_line(rst_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic inr(input int x, input int lo, input int hi);
    chk(32'(x >= lo && x <= hi), 32'h1);
  endtask
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= is_wr;
    read <= !is_wr;
    @(posedge ref_clk);
    while (waitreq !== 1'b0) @(posedge ref_clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  function automatic logic oe_of(input int which);
    return which != 0 ? rst_oe : pwr_oe;
  endfunction
  // Cycles until drive starts, drive length, and level driven
  task automatic pulse(input int which, input int tmo, output int wc, output int len,
                       output logic lvl);
    wc = 0;
    len = 0;
    lvl = 1'bx;
    while (oe_of(which) !== 1'b1 && wc < tmo) begin
      @(posedge ref_clk);
      wc++;
    end
    while (oe_of(which) === 1'b1 && len < 1000) begin
      if (len == 1) lvl = which != 0 ? rst_out : pwr_out;
      @(posedge ref_clk);
      len++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(ADDR_FUNC, {24'h0, FUNC_RST});
    rd(ADDR_PULSE, 32'h20);
    rd(ADDR_SENSE, 32'h01);
    rd(ADDR_STORE, 32'h0);
    rd(5'h18, 32'h0);
    chk({31'h0, pwr_oe}, 32'h0);
    chk({31'h0, rst_oe}, 32'h0);
  endtask
  task automatic t_disabled;
    for (int s = 0; s < 2; s++) begin
      sense_conn <= s[0];
      accept <= 1'b1;
      pulse(s, 140 * T, w, l, v);
      chk(32'(w), 32'(140 * T));
      chk({31'h0, blank}, 32'h0);
      accept <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  task automatic t_config;
    wr(ADDR_FUNC, 8'd241);
    wr(ADDR_PULSE, 8'd16);
    wr(ADDR_SENSE, SENSE_CONNECTOR);
    wr(ADDR_STORE, 8'h00);
    rd(ADDR_FUNC, 32'd241);
    rd(ADDR_PULSE, 32'd16);
    sense_conn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, blank}, 32'h1);
    sense_conn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, blank}, 32'h0);
    // Any select other than the connector value reads the gpio pin
    wr(ADDR_SENSE, 8'h00);
    sense_gpio <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, blank}, 32'h1);
    sense_gpio <= 1'b1;
    wr(ADDR_SENSE, SENSE_CONNECTOR);
  endtask
  // Gpio sense stays high, so only the connector pin may count as host off
  task automatic t_power_on;
    sense_conn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    accept <= 1'b1;
    pulse(0, 20 * T, w, l, v);
    accept <= 1'b0;
    inr(w, 7 * T, 8 * T + 12);
    inr(l, 15 * T, 16 * T + 2);
    chk({31'h0, v}, 32'h0);
    chk({31'h0, pwr_oe}, 32'h0);
  endtask
  task automatic t_hard_off;
    sense_conn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cancel <= 1'b1;
    pulse(0, 140 * T, w, l, v);
    cancel <= 1'b0;
    inr(w, 127 * T, 128 * T + 12);
    inr(l, 175 * T, 176 * T + 2);
    chk({31'h0, v}, 32'h0);
  endtask
  task automatic t_key_reset;
    int n;
    wr(ADDR_PULSE, 8'd8);
    accept <= 1'b1;
    pulse(1, 140 * T, w, l, v);
    accept <= 1'b0;
    inr(w, 127 * T, 128 * T + 12);
    inr(l, 31 * T, 32 * T + 2);
    chk({31'h0, v}, 32'h0);
    n = 0;
    while (restart !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    inr(n, 0, 9);
    repeat (4) @(posedge ref_clk);
    rd(ADDR_PULSE, 32'd16);
    rd(ADDR_FUNC, 32'd241);
  endtask
  // Fixed inversions without auto polarity must drive both lines high
  task automatic t_watchdog;
    wr(ADDR_FUNC, 8'h26);
    wr(ADDR_WDOG, 8'h01);
    pulse(1, 20, w, l, v);
    inr(l, 31 * T, 32 * T + 2);
    chk({31'h0, v}, 32'h1);
    rd(ADDR_WDOG, 32'h0);
    sense_conn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    accept <= 1'b1;
    pulse(0, 20 * T, w, l, v);
    accept <= 1'b0;
    inr(l, 15 * T, 16 * T + 2);
    chk({31'h0, v}, 32'h1);
    chk({31'h0, blank}, 32'h0);
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_disabled();
    t_config();
    t_power_on();
    t_hard_off();
    t_key_reset();
    t_watchdog();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
